// [pmc_regs.sv]
// Management register bank behind the serial management pins
//
// How it works
// - Auto-polarity disabled: no automatic receive polarity correction.
// - Auto-polarity enabled in 10 Mbit: reversed receive pair is inverted.
// - Auto-polarity enabled: polarity bit read-only, shows live inversion.
// - Auto-polarity disabled: polarity bit writable, forces inversion.
// - Bypass bit skips coding sublayer and scrambler in 100 Mbit mode.
// - Clock gating bit stops receive clock in 100 Mbit when idle.
// - Loopback overrides gating; software must not combine gating with bypass.
// - Low byte holds eight event flags set by their events.
// - Reading the interrupt register clears all eight flags.
// - High byte enables each flag onto the PHY interrupt.
// - Interrupt register can be polled at one management address.
// - Flag 7 set on jabber.
// - Flag 6 set on receive error.
// - Flag 5 set on new page received.
// - Flag 4 set on parallel detection fault.
// - Flag 3 set on acknowledged pulse burst.
// - Flag 2 set on link OK to FAIL.
// - Flag 1 set on remote fault.
// - Flag 0 set on negotiation complete.
// - Negotiation failure bit set on no common technology, held until read.
module pmc_regs
  import pmc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         mdc,
  input  wire logic         mdio_in,
  output logic              mdio_out,
  output logic              mdio_oe,
  input  wire pmc_phy_in_t  phy_in,
  output pmc_phy_out_t      phy_out
);

  pmc_st_t     st;
  pmc_st_t     next_st;
  logic        rise;
  logic [11:0] hw;
  logic [15:0] wd;
  logic        clr_ics;
  logic        clr_diag;
  logic        clr_exp;

  // Edge found between second and third stage; the first stage may be metastable
  assign rise     = st.mdc_s & ~st.mdc_d;
  assign hw       = {st.hdr[10:0], st.mdio_s};
  assign wd       = {st.sh[14:0], st.mdio_s};
  assign mdio_out = st.mdio_out;
  assign mdio_oe  = st.mdio_oe;
  assign phy_out  = st.po;

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  function automatic logic [15:0] rd_mux(input pmc_st_t s, input logic [4:0] a,
                                         input pmc_phy_in_t p);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      PMC_OFS_VCTL: begin
        v = s.vctl;
        if (!s.vctl[PMC_B_AUTO_POLARITY_DISABLE]) begin
          v[PMC_B_RVS] = s.po.rx_invert;
        end
      end
      PMC_OFS_ICS:  v = {s.ie, s.flg};
      PMC_OFS_DIAG: v[PMC_B_NEGOTIATION_FAILED] = s.negotiation_failed;
      PMC_OFS_EXP:  v = {11'h000, s.pdf, p.partner_np_able, 1'b0, s.prx, p.partner_an_able};
      default:      v = 16'h0000;
    endcase
    return v;
  endfunction : rd_mux

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // MDC is sampled, so only its synced edge advances the frame decoder
  always_comb begin
    next_st           = st;
    clr_ics           = 1'b0;
    clr_diag          = 1'b0;
    clr_exp           = 1'b0;
    next_st.mdc_meta  = mdc;
    next_st.mdc_s     = st.mdc_meta;
    next_st.mdc_d     = st.mdc_s;
    next_st.mdio_meta = mdio_in;
    next_st.mdio_s    = st.mdio_meta;
    if (rise) begin
      case (st.state)
        PMC_IDLE: begin
          // Preamble may be suppressed: one idle 1 is enough
          if (st.mdio_s) begin
            next_st.seen_one = 1'b1;
          end else if (st.seen_one) begin
            next_st.state = PMC_START;
          end
        end
        PMC_START: begin
          next_st.seen_one = 1'b0;
          next_st.cnt      = 4'h0;
          next_st.state    = st.mdio_s ? PMC_HDR : PMC_IDLE;
        end
        PMC_HDR: begin
          next_st.hdr = hw;
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt == PMC_HDR_LAST) begin
            next_st.mine  = (hw[9:5] == PMC_PHY_ADDR) &&
                            (hw[11:10] == PMC_OP_RD || hw[11:10] == PMC_OP_WR);
            next_st.rd    = hw[11:10] == PMC_OP_RD;
            next_st.sh    = rd_mux(st, hw[4:0], phy_in);
            next_st.cnt   = 4'h0;
            next_st.state = PMC_TA;
            if (hw[9:5] == PMC_PHY_ADDR && hw[11:10] == PMC_OP_RD) begin
              clr_ics  = hw[4:0] == PMC_OFS_ICS;
              clr_diag = hw[4:0] == PMC_OFS_DIAG;
              clr_exp  = hw[4:0] == PMC_OFS_EXP;
            end
          end
        end
        PMC_TA: begin
          // Drive the turnaround zero, then the first data bit
          next_st.cnt = st.cnt + 4'h1;
          if (st.mine && st.rd) begin
            next_st.mdio_oe  = 1'b1;
            next_st.mdio_out = (st.cnt == 4'h0) ? 1'b0 : st.sh[15];
            if (st.cnt != 4'h0) begin
              next_st.sh = {st.sh[14:0], 1'b0};
            end
          end
          if (st.cnt != 4'h0) begin
            next_st.cnt   = 4'h0;
            next_st.state = PMC_DATA;
          end
        end
        PMC_DATA: begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.rd) begin
            next_st.mdio_out = st.sh[15];
            next_st.sh       = {st.sh[14:0], 1'b0};
          end else begin
            next_st.sh = wd;
          end
          if (st.cnt == PMC_DAT_LAST) begin
            next_st.mdio_oe = 1'b0;
            next_st.state   = PMC_IDLE;
            if (st.mine && !st.rd) begin
              if (st.hdr[4:0] == PMC_OFS_VCTL) begin
                next_st.vctl = (st.vctl & ~PMC_VCTL_WMASK) | (wd & PMC_VCTL_WMASK);
                // Polarity bit only takes a write whose data also sets the auto-polarity disable bit
                if (wd[PMC_B_AUTO_POLARITY_DISABLE]) begin
                  next_st.vctl[PMC_B_RVS] = wd[PMC_B_RVS];
                end
              end
              if (st.hdr[4:0] == PMC_OFS_ICS) begin
                next_st.ie = wd[15:8];
              end
            end
          end
        end
        default: next_st.state = PMC_IDLE;
      endcase
    end
    // Sticky flags: a set in the clearing cycle wins
    next_st.flg   = (clr_ics ? 8'h00 : st.flg) | phy_in.ev;
    next_st.negotiation_failed = (clr_diag ? 1'b0 : st.negotiation_failed) | phy_in.neg_failed;
    next_st.pdf   = (clr_exp ? 1'b0 : st.pdf) | phy_in.ev[PMC_EV_PDF];
    next_st.prx   = (clr_exp ? 1'b0 : st.prx) | phy_in.ev[PMC_EV_PRX];
    // Datapath controls, registered so outputs leave flip-flops
    next_st.po.rx_invert = st.vctl[PMC_B_AUTO_POLARITY_DISABLE] ? st.vctl[PMC_B_RVS]
                           : (phy_in.speed_10 & phy_in.wrong_polarity);
    next_st.po.coding_sublayer_bypass = st.vctl[PMC_B_BYP] & phy_in.speed_100;
    // Loopback needs the clock, so it overrides gating
    next_st.po.rx_clock_stop = st.vctl[PMC_B_RECEIVE_CLOCK_GATING] & phy_in.speed_100
                               & ~phy_in.rx_active & ~phy_in.loopback_select;
    next_st.po.phy_interrupt = |(st.flg & st.ie);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st       <= '0;
      st.state <= PMC_IDLE;
      st.vctl  <= PMC_VCTL_RST;
      st.ie    <= PMC_ICS_RST;
      st.flg   <= PMC_ICS_RST;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_FORCED_POL: assert property (st.vctl[PMC_B_AUTO_POLARITY_DISABLE] |=>
    st.po.rx_invert == $past(st.vctl[PMC_B_RVS])) else $error("forced polarity lost");
  AST_AUTO_POL: assert property (!st.vctl[PMC_B_AUTO_POLARITY_DISABLE] && phy_in.speed_10
    && phy_in.wrong_polarity |=> st.po.rx_invert) else $error("auto polarity missed");
  AST_BYPASS: assert property (!phy_in.speed_100 |=>
    !st.po.coding_sublayer_bypass) else $error("bypass outside 100 Mbit");
  AST_GATE: assert property (st.vctl[PMC_B_RECEIVE_CLOCK_GATING] && phy_in.speed_100 &&
    !phy_in.rx_active && !phy_in.loopback_select |=> st.po.rx_clock_stop)
    else $error("receive clock not stopped");
  AST_LOOP: assert property (phy_in.loopback_select |=>
    !st.po.rx_clock_stop) else $error("gating during loopback");
  AST_SET: assert property (phy_in.ev != 8'h00 |=>
    (st.flg & $past(phy_in.ev)) == $past(phy_in.ev)) else $error("event flag lost");
  AST_CLR: assert property (clr_ics && phy_in.ev == 8'h00 |=>
    st.flg == 8'h00) else $error("flags not cleared by read");
  AST_IRQ: assert property ((st.flg & st.ie) != 8'h00 |=>
    st.po.phy_interrupt) else $error("enabled flag raised no interrupt");
  AST_NEGOTIATION_FAILED: assert property (phy_in.neg_failed |=> st.negotiation_failed ##0
    (st.negotiation_failed || $past(clr_diag))[*2]) else $error("failure bit not held");
  AST_DRIVE: assert property (st.mdio_oe |->
    (st.state == PMC_TA || st.state == PMC_DATA || $past(st.state) == PMC_DATA))
    else $error("data pin driven outside a read");

  COV_POLL: cover property (clr_ics ##1 st.flg == 8'h00);
  COV_WRITE: cover property (rise && st.state == PMC_DATA && !st.rd
    && st.cnt == PMC_DAT_LAST);
  COV_IRQ: cover property (!st.po.phy_interrupt ##1 st.po.phy_interrupt);

endmodule : pmc_regs

// [pmc_pkg.sv]
// Shared constants and types for the PHY management control/status bank
package pmc_pkg;

  // ------------------------------------------------------------
  // Management frame and register map
  // ------------------------------------------------------------
  localparam logic [4:0]  PMC_PHY_ADDR   = 5'h01;   // Bank answers this address
  localparam logic [1:0]  PMC_OP_RD      = 2'b10;
  localparam logic [1:0]  PMC_OP_WR      = 2'b01;
  localparam logic [3:0]  PMC_HDR_LAST   = 4'h0b;   // Op, address, register: 12 bits
  localparam logic [3:0]  PMC_DAT_LAST   = 4'h0f;   // 16 data bits
  localparam logic [4:0]  PMC_OFS_EXP    = 5'h06;
  localparam logic [4:0]  PMC_OFS_VCTL   = 5'h10;
  localparam logic [4:0]  PMC_OFS_ICS    = 5'h11;
  localparam logic [4:0]  PMC_OFS_DIAG   = 5'h12;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] PMC_VCTL_RST   = 16'h0140;
  localparam logic [15:0] PMC_VCTL_WMASK = 16'hdc23; // Writable, polarity bit apart
  localparam int          PMC_B_AUTO_POLARITY_DISABLE     = 5;
  localparam int          PMC_B_RVS      = 4;
  localparam int          PMC_B_BYP      = 1;
  localparam int          PMC_B_RECEIVE_CLOCK_GATING     = 0;
  localparam int          PMC_B_NEGOTIATION_FAILED    = 12;
  localparam int          PMC_EV_PRX     = 5;
  localparam int          PMC_EV_PDF     = 4;
  localparam logic [7:0]  PMC_ICS_RST    = 8'h00;

  typedef enum logic [2:0] {
    PMC_IDLE  = 3'b000,
    PMC_START = 3'b001,
    PMC_HDR   = 3'b011,
    PMC_TA    = 3'b010,
    PMC_DATA  = 3'b110
  } pmc_state_t;

  // Status and events from the PHY datapath and negotiation engine
  typedef struct packed {
    logic [7:0] ev;              // One-cycle event pulses, bit per flag
    logic       neg_failed;      // No common technology found
    logic       speed_10;
    logic       speed_100;
    logic       loopback_select;
    logic       wrong_polarity;  // Receive pair seen reversed
    logic       rx_active;       // Data arriving from the medium
    logic       partner_np_able;
    logic       partner_an_able;
  } pmc_phy_in_t;

  // Controls back to the datapath and the MAC interrupt status
  typedef struct packed {
    logic rx_invert;
    logic coding_sublayer_bypass;
    logic rx_clock_stop;
    logic phy_interrupt;
  } pmc_phy_out_t;

  typedef struct packed {
    logic        mdc_meta;
    logic        mdc_s;
    logic        mdc_d;
    logic        mdio_meta;
    logic        mdio_s;
    pmc_state_t  state;
    logic [3:0]  cnt;
    logic        seen_one;
    logic [11:0] hdr;
    logic        mine;
    logic        rd;
    logic [15:0] sh;
    logic        mdio_out;
    logic        mdio_oe;
    logic [15:0] vctl;
    logic [7:0]  ie;
    logic [7:0]  flg;
    logic        negotiation_failed;
    logic        pdf;
    logic        prx;
    pmc_phy_out_t po;
  } pmc_st_t;

endpackage : pmc_pkg

// [pmc_mdio_model.sv]
// Management-side controller model for the serial management pins
module pmc_mdio_model
  import pmc_pkg::*;
(
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv;
  logic val;

  // Line level; a pull-up holds it high when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (drv ? val : 1'b1);

  // Clock stands low between frames
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    val = 1'b1;
  end

  // ----------------------------------------------------------
  // One whole frame, data changed while the clock is low
  // ----------------------------------------------------------
  task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [33:0] b;
    b = {2'b11, 2'b01, rd ? PMC_OP_RD : PMC_OP_WR, phy, ra, 2'b10, wd};
    rdat = 16'h0000;
    for (int i = 33; i >= 0; i--) begin
      drv = !(rd && i < 18);  // Released over turnaround and read data
      val = b[i];
      #62.5 mdc = 1'b1;
      if (i < 16) begin
        rdat[i] = mdio_in;
      end
      #62.5 mdc = 1'b0;
    end
    drv = 1'b0;
  endtask : frame
endmodule : pmc_mdio_model

// [tb.sv]
// Self-checking bench for the management register bank
module tb
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic         sys_clk;
  logic         rst_n;
  logic         mdc;
  logic         mdio_in;
  logic         mdio_out;
  logic         mdio_oe;
  pmc_phy_in_t  phy_in;
  pmc_phy_out_t phy_out;
  int           n_mismatch = 0;
  int           checked = 0;
  int           cycles = 0;

  pmc_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_in(phy_in), .phy_out(phy_out));
  pmc_mdio_model mm_u (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe));

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // Controls land one cycle after their cause; two leaves margin
  task automatic co(input string w, input logic [3:0] e);
    tick(2);
    chk(w, {12'h000, e}, {12'h000, phy_out});
  endtask : co

  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    mm_u.frame(PMC_PHY_ADDR, 1'b1, ra, 16'h0000, d);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mm_u.frame(PMC_PHY_ADDR, 1'b0, ra, d, x);
  endtask : wr

  task automatic rdc(input string w, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] d;
    rd(ra, d);
    chk(w, e, d);
  endtask : rdc

  // Bit 8+i is event i, bit 7 the negotiation failure
  task automatic pulse(input int b);
    tick(1);
    phy_in[b] = 1'b1;
    tick(1);
    phy_in[b] = 1'b0;
  endtask : pulse

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    co("controls after reset", 4'b0000);
    rdc("vendor reset", PMC_OFS_VCTL, 16'h0140);
    rdc("events reset", PMC_OFS_ICS, 16'h0000);
    rdc("diag reset", PMC_OFS_DIAG, 16'h0000);
  endtask : t_reset

  task automatic t_events;
    for (int i = 0; i < 8; i++) begin
      pulse(8 + i);
      co("masked irq", 4'b0000);
      rdc("event flag", PMC_OFS_ICS, 16'h0001 << i);
      rdc("flag cleared", PMC_OFS_ICS, 16'h0000);
    end
    rdc("expansion flags", PMC_OFS_EXP, 16'h0012);
    phy_in.partner_np_able = 1'b1;
    phy_in.partner_an_able = 1'b1;
    rdc("expansion live", PMC_OFS_EXP, 16'h0009);
  endtask : t_events

  // Low byte write must not plant flags
  task automatic t_enable;
    wr(PMC_OFS_ICS, 16'h01ff);
    pulse(9);
    co("other flag masked", 4'b0000);
    pulse(8);
    co("enabled flag", 4'b0001);
    rdc("polled status", PMC_OFS_ICS, 16'h0103);
    co("irq after clear", 4'b0000);
    wr(PMC_OFS_ICS, 16'h0000);
  endtask : t_enable

  // An event near the clearing moment must show in one of two reads
  task automatic t_race;
    logic [15:0] a;
    logic [15:0] b;
    for (int k = 0; k < 8; k++) begin
      fork
        rd(PMC_OFS_ICS, a);
        begin
          repeat (16) @(posedge mdc);
          repeat (k) @(posedge sys_clk);
          pulse(14);
        end
      join
      rd(PMC_OFS_ICS, b);
      chk("event kept", 16'h0040, (a | b) & 16'h0040);
    end
  endtask : t_race

  task automatic t_vendor;
    tick(1);
    phy_in.speed_10 = 1'b1;
    phy_in.wrong_polarity = 1'b1;
    wr(PMC_OFS_VCTL, 16'h0020);
    co("no auto invert", 4'b0000);
    rdc("forced off", PMC_OFS_VCTL, 16'h0160);
    wr(PMC_OFS_VCTL, 16'h0030);
    co("forced invert", 4'b1000);
    wr(PMC_OFS_VCTL, 16'hfffc);
    rdc("read-only bits", PMC_OFS_VCTL, 16'hdd70);
    wr(PMC_OFS_VCTL, 16'h0000);
    co("auto invert", 4'b1000);
    rdc("live polarity", PMC_OFS_VCTL, 16'h0150);
    phy_in.speed_10 = 1'b0;
    co("no invert at 100", 4'b0000);
    rdc("polarity idle", PMC_OFS_VCTL, 16'h0140);
  endtask : t_vendor

  // Bypass and gating are never set together
  task automatic t_ctrl;
    tick(1);
    phy_in.speed_100 = 1'b1;
    wr(PMC_OFS_VCTL, 16'h0002);
    co("bypass", 4'b0100);
    wr(PMC_OFS_VCTL, 16'h0001);
    co("clock stopped", 4'b0010);
    phy_in.rx_active = 1'b1;
    co("clock runs on data", 4'b0000);
    phy_in.rx_active = 1'b0;
    phy_in.loopback_select = 1'b1;
    co("loopback ungates", 4'b0000);
    phy_in.loopback_select = 1'b0;
    phy_in.speed_100 = 1'b0;
    co("no gating at 10", 4'b0000);
    wr(PMC_OFS_VCTL, 16'h0000);
  endtask : t_ctrl

  task automatic t_diag;
    logic [15:0] d;
    pulse(7);
    rdc("vendor between", PMC_OFS_VCTL, 16'h0140);
    rdc("negotiation failed", PMC_OFS_DIAG, 16'h1000);
    rdc("failure cleared", PMC_OFS_DIAG, 16'h0000);
    pulse(15);
    mm_u.frame(5'h02, 1'b1, PMC_OFS_ICS, 16'h0000, d);
    chk("foreign frame idle", 16'hffff, d);
    wr(5'h1f, 16'hffff);
    rdc("unmapped", 5'h1f, 16'h0000);
    rdc("flag survives", PMC_OFS_ICS, 16'h0080);
  endtask : t_diag

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    phy_in = '0;
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_events();
    t_enable();
    t_race();
    t_vendor();
    t_ctrl();
    t_diag();
    report_and_stop();
  end
endmodule : tb
